// File: rtl/baro_regs_pkg.sv
// Package: register map, field layout, reset values and timing of the barometer control registers
package baro_regs_pkg;

  localparam logic [6:0] ADDR_RATE_FILTER   = 7'h10;
  localparam logic [6:0] ADDR_SYSTEM_QUEUE  = 7'h11;
  localparam logic [6:0] ADDR_IRQ_PIN       = 7'h12;
  localparam logic [6:0] ADDR_QUEUE_CTRL    = 7'h14;
  localparam logic [6:0] ADDR_REF_LOW       = 7'h15;
  localparam logic [6:0] ADDR_REF_MID       = 7'h16;
  localparam logic [6:0] ADDR_REF_HIGH      = 7'h17;
  localparam logic [6:0] ADDR_OFS_LOW       = 7'h18;
  localparam logic [6:0] ADDR_OFS_HIGH      = 7'h19;
  localparam logic [6:0] ADDR_LOW_POWER     = 7'h1A;

  localparam logic [7:0] RST_RATE_FILTER    = 8'h00;
  localparam logic [7:0] RST_SYSTEM_QUEUE   = 8'h10;
  localparam logic [7:0] RST_IRQ_PIN        = 8'h00;
  localparam logic [7:0] RST_QUEUE_CTRL     = 8'h00;
  localparam logic [7:0] RST_ZERO           = 8'h00;

  // Control register 2 bit positions
  localparam int BIT_TRIM_RELOAD   = 7;
  localparam int BIT_QUEUE_ON      = 6;
  localparam int BIT_HALT_WM       = 5;
  localparam int BIT_AUTOINC       = 4;
  localparam int BIT_TWOWIRE_OFF   = 3;
  localparam int BIT_SOFT_RESET    = 2;
  localparam int BIT_SINGLE_CONV   = 0;

  // Cycles for one conversion at 20 MHz, and words in the reload sequence
  localparam int CLK_HZ           = 20_000_000;
  localparam int CONV_TIME_US     = 10;
  localparam int CONV_CYCLES      = (CLK_HZ / 1_000_000) * CONV_TIME_US;
  localparam int TRIM_WORDS       = 8;

  typedef enum logic [2:0] {
    RATE_SINGLE = 3'h0, RATE_1HZ = 3'h1, RATE_10HZ = 3'h2,
    RATE_25HZ = 3'h3, RATE_50HZ = 3'h4, RATE_75HZ = 3'h5
  } rate_code_t;

  typedef enum logic [2:0] {
    QM_BYPASS = 3'h0, QM_FIFO = 3'h1, QM_STREAM = 3'h2,
    QM_STREAM_FIFO = 3'h3, QM_BYP_STREAM = 3'h4, QM_BYP_FIFO = 3'h7
  } queue_mode_t;

  typedef struct packed {
    logic [2:0] sample_rate_sel;
    logic       press_lpf_on;
    logic       lpf_cutoff_sel;
    logic       hold_until_read;
    logic       spi_wire_sel;
    logic       queue_on;
    logic       halt_at_watermark;
    logic       addr_autoinc;
    logic       twowire_off;
    logic       irq_polarity;
    logic       irq_drive_sel;
    logic       queue_full_route;
    logic       watermark_route;
    logic       overrun_route;
    logic       data_ready_route;
    logic [1:0] pin_source_sel;
    logic [2:0] queue_mode_sel;
    logic [4:0] watermark_level;
    logic       low_current_sel;
  } config_t;

  typedef struct packed {
    logic sample_ready_signal;
    logic watermark;
    logic overrun;
    logic queue_full;
    logic press_high;
    logic press_low;
  } events_t;

endpackage

// File: rtl/trim_store.sv
// Small trimming memory: registered read, loaded from nonvolatile words
module trim_store (
  input  wire logic       sys_clk,   // System clock
  input  wire logic       reset_n,   // Async reset, active low
  input  wire logic       wr_en,     // Write one word
  input  wire logic [2:0] wr_addr,   // Write index
  input  wire logic [7:0] wr_data,   // Write word
  input  wire logic [2:0] rd_addr,   // Read index
  output logic      [7:0] rd_data    // Registered read word
);
  logic [7:0] mem_q [8];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule

// File: rtl/rate_timer.sv
// Sample-rate timebase: one-cycle tick per output-data-rate period
module rate_timer (
  input  wire logic       sys_clk,   // System clock
  input  wire logic       reset_n,   // Async reset, active low
  input  wire logic [2:0] rate_sel,  // Sample rate code
  output logic            tick       // Period pulse
);
  logic [24:0] count_q;
  logic [24:0] limit;

  // Divider terminal counts at 20 MHz
  function automatic logic [24:0] period_of(input logic [2:0] r);
    unique case (r)
      3'h1:    period_of = 25'(20_000_000 - 1);
      3'h2:    period_of = 25'(2_000_000 - 1);
      3'h3:    period_of = 25'(800_000 - 1);
      3'h4:    period_of = 25'(400_000 - 1);
      3'h5:    period_of = 25'(266_666 - 1);
      default: period_of = 25'h0000000;
    endcase
  endfunction

  assign limit = period_of(rate_sel);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 25'h0000000;
      tick    <= 1'b0;
    end else if (limit == 25'h0000000) begin
      count_q <= 25'h0000000;
      tick    <= 1'b0;
    end else if (count_q >= limit) begin
      count_q <= 25'h0000000;
      tick    <= 1'b1;
    end else begin
      count_q <= count_q + 25'h0000001;
      tick    <= 1'b0;
    end
  end
endmodule

// File: rtl/baro_control_regs.sv
// Control and configuration register bank of the barometric sensor
module baro_control_regs (
  input  wire logic                    sys_clk,        // 20 MHz clock
  input  wire logic                    reset_n,        // Async reset, active low
  input  wire logic                    wr_en,          // Register write strobe
  input  wire logic                    rd_en,          // Register read strobe
  input  wire logic [6:0]              reg_addr,       // Register address
  input  wire logic [7:0]              wr_data,        // Write data
  input  wire logic                    out_upper_rd,   // Upper output byte read
  input  wire logic                    out_lower_rd,   // Lower output byte read
  input  wire baro_regs_pkg::events_t  events_in,      // Core event levels
  input  wire logic [7:0]              nvm_data,       // Nonvolatile trim word
  output logic      [7:0]              rd_data,        // Read data, one cycle after rd_en
  output baro_regs_pkg::config_t       cfg,            // Registered configuration
  output logic      [23:0]             ref_pressure,   // Reference pressure
  output logic      [15:0]             press_offset,   // Pressure offset
  output logic                         conv_start,     // Measurement start pulse
  output logic                         conv_busy,      // Single-shot measurement in progress
  output logic                         out_update_en,  // Output registers may update
  output logic                         twowire_en,     // I2C interface answers
  output logic      [2:0]              nvm_addr,       // Trim word index
  output logic      [7:0]              trim_word,      // Last trim word read back
  output logic                         irq_pin_o,      // Interrupt pin output
  output logic                         irq_pin_oe_n    // Interrupt pin enable, low drives
);

  logic [7:0]  ctrl1_q, ctrl2_q, ctrl3_q, qctrl_q, lowp_q;
  logic [23:0] ref_q;
  logic [15:0] ofs_q;
  logic        single_busy_q, trim_busy_q, reset_pend_q;
  logic [15:0] conv_cnt_q;
  logic        odr_tick;
  logic        trim_arm_q;
  logic [2:0]  trim_idx_q;
  logic        trim_wr_q;
  logic        trim_wr_dly_q;
  logic        upper_seen_q, lower_seen_q;
  logic        irq_level;
  logic [7:0]  trim_rd;

  function automatic logic wr_hit(input logic [6:0] a);
    wr_hit = wr_en && (reg_addr == a);
  endfunction

  rate_timer u_rate (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .rate_sel (ctrl1_q[6:4]),
    .tick     (odr_tick)
  );

  trim_store u_trim (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .wr_en   (trim_wr_dly_q),
    .wr_addr (nvm_addr),
    .wr_data (nvm_data),
    .rd_addr (trim_idx_q),
    .rd_data (trim_rd)
  );

  // Rate/filter control; bit 7 forced to zero since host must not set it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1_q <= baro_regs_pkg::RST_RATE_FILTER;
    end else if (reset_pend_q && !trim_busy_q) begin
      ctrl1_q <= baro_regs_pkg::RST_RATE_FILTER;
    end else if (wr_hit(baro_regs_pkg::ADDR_RATE_FILTER)) begin
      ctrl1_q <= {1'b0, wr_data[6:0]};
    end
  end

  // Control 2 stores only the non-self-clearing bits here
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl2_q <= baro_regs_pkg::RST_SYSTEM_QUEUE;
    end else if (reset_pend_q && !trim_busy_q) begin
      ctrl2_q <= baro_regs_pkg::RST_SYSTEM_QUEUE;
    end else if (wr_hit(baro_regs_pkg::ADDR_SYSTEM_QUEUE)) begin
      ctrl2_q <= {1'b0, wr_data[6:3], 3'h0};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl3_q <= baro_regs_pkg::RST_IRQ_PIN;
      qctrl_q <= baro_regs_pkg::RST_QUEUE_CTRL;
      lowp_q  <= baro_regs_pkg::RST_ZERO;
    end else if (reset_pend_q && !trim_busy_q) begin
      ctrl3_q <= baro_regs_pkg::RST_IRQ_PIN;
      qctrl_q <= baro_regs_pkg::RST_QUEUE_CTRL;
      lowp_q  <= baro_regs_pkg::RST_ZERO;
    end else begin
      if (wr_hit(baro_regs_pkg::ADDR_IRQ_PIN)) begin
        ctrl3_q <= wr_data;
      end
      // Reserved mode codes are stored as written; host must avoid them
      if (wr_hit(baro_regs_pkg::ADDR_QUEUE_CTRL)) begin
        qctrl_q <= wr_data;
      end
      if (wr_hit(baro_regs_pkg::ADDR_LOW_POWER)) begin
        lowp_q <= {7'h00, wr_data[0]};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ref_q <= 24'h000000;
      ofs_q <= 16'h0000;
    end else if (reset_pend_q && !trim_busy_q) begin
      ref_q <= 24'h000000;
      ofs_q <= 16'h0000;
    end else begin
      if (wr_hit(baro_regs_pkg::ADDR_REF_LOW))  ref_q[7:0]   <= wr_data;
      if (wr_hit(baro_regs_pkg::ADDR_REF_MID))  ref_q[15:8]  <= wr_data;
      if (wr_hit(baro_regs_pkg::ADDR_REF_HIGH)) ref_q[23:16] <= wr_data;
      if (wr_hit(baro_regs_pkg::ADDR_OFS_LOW))  ofs_q[7:0]   <= wr_data;
      if (wr_hit(baro_regs_pkg::ADDR_OFS_HIGH)) ofs_q[15:8]  <= wr_data;
    end
  end

  // Single-shot measurement: only honoured in single-shot rate
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      single_busy_q <= 1'b0;
      conv_cnt_q    <= 16'h0000;
      conv_start    <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (!single_busy_q && wr_hit(baro_regs_pkg::ADDR_SYSTEM_QUEUE)
          && wr_data[baro_regs_pkg::BIT_SINGLE_CONV] && ctrl1_q[6:4] == 3'h0) begin
        single_busy_q <= 1'b1;
        conv_start    <= 1'b1;
        conv_cnt_q    <= 16'(baro_regs_pkg::CONV_CYCLES - 1);
      end else if (single_busy_q) begin
        if (conv_cnt_q == 16'h0000) begin
          single_busy_q <= 1'b0;
        end else begin
          conv_cnt_q <= conv_cnt_q - 16'h0001;
        end
      end else if (odr_tick) begin
        conv_start <= 1'b1;
      end
    end
  end

  property p_single_start;
    @(posedge sys_clk) disable iff (!reset_n)
      wr_en && reg_addr == baro_regs_pkg::ADDR_SYSTEM_QUEUE && wr_data[baro_regs_pkg::BIT_SINGLE_CONV]
      && !single_busy_q && ctrl1_q[6:4] == 3'h0 |=> single_busy_q && conv_start;
  endproperty
  a_single_start: assert property (p_single_start) else $error("Single trigger did not start");
  property p_single_length;
    @(posedge sys_clk) disable iff (!reset_n)
      $rose(single_busy_q) |-> ##199 single_busy_q ##1 !single_busy_q;
  endproperty
  a_single_length: assert property (p_single_length) else $error("Single busy length wrong");

  // Trim reload waits for the next rate tick (at once in single-shot rate), then copies all trim words
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_busy_q  <= 1'b0;
      trim_arm_q   <= 1'b0;
      trim_idx_q   <= 3'h0;
      trim_wr_q    <= 1'b0;
      trim_wr_dly_q <= 1'b0;
      reset_pend_q <= 1'b0;
    end else begin
      // Trim word arrives a cycle after its index, so the write trails too
      trim_wr_dly_q <= trim_wr_q;
      if (!trim_busy_q && wr_hit(baro_regs_pkg::ADDR_SYSTEM_QUEUE)
          && wr_data[baro_regs_pkg::BIT_TRIM_RELOAD]) begin
        trim_busy_q  <= 1'b1;
        trim_arm_q   <= 1'b0;
        trim_idx_q   <= 3'h0;
        reset_pend_q <= wr_data[baro_regs_pkg::BIT_SOFT_RESET];
      end else if (trim_busy_q && !trim_arm_q) begin
        // No running timebase in single-shot rate: proceed at once
        if (odr_tick || ctrl1_q[6:4] == 3'h0) begin
          trim_arm_q <= 1'b1;
          trim_wr_q  <= 1'b1;
        end
      end else if (trim_busy_q) begin
        if (trim_idx_q == 3'(baro_regs_pkg::TRIM_WORDS - 1)) begin
          trim_busy_q <= 1'b0;
          trim_wr_q   <= 1'b0;
        end else begin
          trim_idx_q <= trim_idx_q + 3'h1;
        end
      end else if (reset_pend_q) begin
        reset_pend_q <= 1'b0;
      end
    end
  end

  property p_trim_done;
    @(posedge sys_clk) disable iff (!reset_n)
      $fell(trim_busy_q) |-> trim_idx_q == 3'(baro_regs_pkg::TRIM_WORDS - 1);
  endproperty
  a_trim_done: assert property (p_trim_done) else $error("Trim reload ended early");
  property p_soft_restore;
    @(posedge sys_clk) disable iff (!reset_n)
      $fell(reset_pend_q) |-> ctrl1_q == baro_regs_pkg::RST_RATE_FILTER
      && ctrl2_q == baro_regs_pkg::RST_SYSTEM_QUEUE && qctrl_q == baro_regs_pkg::RST_QUEUE_CTRL;
  endproperty
  a_soft_restore: assert property (p_soft_restore) else $error("Soft reset left non-default state");

  // Output hold: once a sample is held, release after both halves read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      upper_seen_q  <= 1'b0;
      lower_seen_q  <= 1'b0;
      out_update_en <= 1'b1;
    end else if (!ctrl1_q[1]) begin
      upper_seen_q  <= 1'b0;
      lower_seen_q  <= 1'b0;
      out_update_en <= 1'b1;
    end else begin
      if (out_upper_rd) upper_seen_q <= 1'b1;
      if (out_lower_rd) lower_seen_q <= 1'b1;
      if ((upper_seen_q || out_upper_rd) && (lower_seen_q || out_lower_rd)) begin
        upper_seen_q  <= 1'b0;
        lower_seen_q  <= 1'b0;
        out_update_en <= 1'b1;
      end else if (out_update_en && (out_upper_rd || out_lower_rd)) begin
        out_update_en <= 1'b0;
      end
    end
  end

  property p_hold_off_free;
    @(posedge sys_clk) disable iff (!reset_n)
      !ctrl1_q[1] |=> out_update_en;
  endproperty
  a_hold_off_free: assert property (p_hold_off_free) else $error("Outputs blocked with hold off");

  // Pin source and event routing, priority order for data signal
  always_comb begin
    irq_level = 1'b0;
    unique case (ctrl3_q[1:0])
      2'h0: begin
        if (ctrl3_q[2] && events_in.sample_ready_signal) irq_level = 1'b1;
        else if (ctrl3_q[4] && events_in.watermark)      irq_level = 1'b1;
        else if (ctrl3_q[3] && events_in.overrun)        irq_level = 1'b1;
        else if (ctrl3_q[5] && events_in.queue_full)     irq_level = 1'b1;
      end
      2'h1: irq_level = events_in.press_high;
      2'h2: irq_level = events_in.press_low;
      2'h3: irq_level = events_in.press_high || events_in.press_low;
    endcase
  end

  // Open drain only ever pulls to the active level
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pin_o    <= 1'b0;
      irq_pin_oe_n <= 1'b0;
    end else begin
      irq_pin_o    <= irq_level ^ ctrl3_q[7];
      irq_pin_oe_n <= ctrl3_q[6] && !irq_level;
    end
  end

  property p_push_pull_drives;
    @(posedge sys_clk) disable iff (!reset_n)
      !ctrl3_q[6] |=> !irq_pin_oe_n;
  endproperty
  a_push_pull_drives: assert property (p_push_pull_drives) else $error("Push-pull pin not driven");
  property p_press_high_src;
    @(posedge sys_clk) disable iff (!reset_n)
      ctrl3_q[1:0] == 2'h1 |=> irq_pin_o == ($past(events_in.press_high) ^ $past(ctrl3_q[7]));
  endproperty
  a_press_high_src: assert property (p_press_high_src) else $error("Pin not following high event");

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      unique case (reg_addr)
        baro_regs_pkg::ADDR_RATE_FILTER:  rd_data <= ctrl1_q;
        baro_regs_pkg::ADDR_SYSTEM_QUEUE: rd_data <= {trim_busy_q || trim_wr_dly_q, ctrl2_q[6:3],
                                                      reset_pend_q, 1'b0, single_busy_q};
        baro_regs_pkg::ADDR_IRQ_PIN:      rd_data <= ctrl3_q;
        baro_regs_pkg::ADDR_QUEUE_CTRL:   rd_data <= qctrl_q;
        baro_regs_pkg::ADDR_REF_LOW:      rd_data <= ref_q[7:0];
        baro_regs_pkg::ADDR_REF_MID:      rd_data <= ref_q[15:8];
        baro_regs_pkg::ADDR_REF_HIGH:     rd_data <= ref_q[23:16];
        baro_regs_pkg::ADDR_OFS_LOW:      rd_data <= ofs_q[7:0];
        baro_regs_pkg::ADDR_OFS_HIGH:     rd_data <= ofs_q[15:8];
        baro_regs_pkg::ADDR_LOW_POWER:    rd_data <= lowp_q;
        default:                          rd_data <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg          <= '0;
      ref_pressure <= 24'h000000;
      press_offset <= 16'h0000;
      conv_busy    <= 1'b0;
      twowire_en   <= 1'b1;
      nvm_addr     <= 3'h0;
      trim_word    <= 8'h00;
    end else begin
      cfg.sample_rate_sel   <= ctrl1_q[6:4];
      cfg.press_lpf_on      <= ctrl1_q[3];
      cfg.lpf_cutoff_sel    <= ctrl1_q[2];
      cfg.hold_until_read   <= ctrl1_q[1];
      cfg.spi_wire_sel      <= ctrl1_q[0];
      cfg.queue_on          <= ctrl2_q[baro_regs_pkg::BIT_QUEUE_ON];
      cfg.halt_at_watermark <= ctrl2_q[baro_regs_pkg::BIT_HALT_WM];
      cfg.addr_autoinc      <= ctrl2_q[baro_regs_pkg::BIT_AUTOINC];
      cfg.twowire_off       <= ctrl2_q[baro_regs_pkg::BIT_TWOWIRE_OFF];
      cfg.irq_polarity      <= ctrl3_q[7];
      cfg.irq_drive_sel     <= ctrl3_q[6];
      cfg.queue_full_route  <= ctrl3_q[5];
      cfg.watermark_route   <= ctrl3_q[4];
      cfg.overrun_route     <= ctrl3_q[3];
      cfg.data_ready_route  <= ctrl3_q[2];
      cfg.pin_source_sel    <= ctrl3_q[1:0];
      cfg.queue_mode_sel    <= qctrl_q[7:5];
      cfg.watermark_level   <= qctrl_q[4:0];
      cfg.low_current_sel   <= lowp_q[0];
      ref_pressure          <= ref_q;
      press_offset          <= ofs_q;
      conv_busy             <= single_busy_q;
      twowire_en            <= !ctrl2_q[baro_regs_pkg::BIT_TWOWIRE_OFF];
      nvm_addr              <= trim_idx_q;
      trim_word             <= trim_rd;
    end
  end

endmodule

// File: tb/host_model.sv
// Host-side model: register writes and reads on the bank's strobe bus
module host_model (
  input  wire logic       sys_clk,   // System clock
  output logic            wr_en,     // Write strobe
  output logic            rd_en,     // Read strobe
  output logic      [6:0] reg_addr,  // Register address
  output logic      [7:0] wr_data,   // Write data
  input  wire logic [7:0] rd_data    // Read data
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    reg_addr = 7'h00;
    wr_data = 8'h00;
  end

  // Keep set: honour the reserved-bit duties; clear only for refusal tests
  task automatic write_reg(input logic [6:0] a, input logic [7:0] d, input logic keep);
    logic [7:0] v;
    v = d;
    if (keep && a == 7'h10) v[7] = 1'b0;
    if (keep && a == 7'h11) v[1] = 1'b0;
    if (keep && a == 7'h1A) v[7:1] = 7'h00;
    @(negedge sys_clk);
    wr_en = 1'b1;
    reg_addr = a;
    wr_data = v;
    @(negedge sys_clk);
    wr_en = 1'b0;
    // Released bus shows the inverse, never the stale value
    reg_addr = ~a;
    wr_data = ~v;
  endtask

  task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    rd_en = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    rd_en = 1'b0;
    reg_addr = ~a;
    @(negedge sys_clk);
    d = rd_data;
  endtask
endmodule

// File: tb/tb.sv
// Testbench: register bank against a bench model, with pin and self-clear checks
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   sys_clk = 1'b0;
  logic                   reset_n = 1'b0;
  logic                   out_upper_rd = 1'b0;
  logic                   out_lower_rd = 1'b0;
  baro_regs_pkg::events_t events_in = '0;
  baro_regs_pkg::config_t cfg;
  logic            [7:0]  nvm_data, rd_data, trim_word, wr_data, d, v;
  logic            [6:0]  reg_addr, a;
  logic            [2:0]  nvm_addr;
  logic                   wr_en, rd_en, conv_start, conv_busy, out_update_en, twowire_en, irq_pin_o, irq_pin_oe_n, act;
  logic            [23:0] ref_pressure;
  logic            [15:0] press_offset;
  logic            [7:0]  mem [0:127];
  logic            [6:0]  amap [0:9];
  int                     bad_count = 0, n_compared = 0, seed = 57753, cyc = 0, n_start = 0, k;

  always #25 sys_clk = ~sys_clk;
  assign nvm_data = 8'hC3 ^ {5'h00, nvm_addr};
  always @(posedge sys_clk) if (conv_start === 1'b1) n_start++;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  baro_control_regs u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr),
    .wr_data(wr_data), .out_upper_rd(out_upper_rd), .out_lower_rd(out_lower_rd), .events_in(events_in),
    .nvm_data(nvm_data), .rd_data(rd_data), .cfg(cfg), .ref_pressure(ref_pressure), .press_offset(press_offset),
    .conv_start(conv_start), .conv_busy(conv_busy), .out_update_en(out_update_en), .twowire_en(twowire_en),
    .nvm_addr(nvm_addr), .trim_word(trim_word), .irq_pin_o(irq_pin_o), .irq_pin_oe_n(irq_pin_oe_n));
  host_model u_host (.sys_clk(sys_clk), .wr_en(wr_en), .rd_en(rd_en), .reg_addr(reg_addr), .wr_data(wr_data),
    .rd_data(rd_data));

  function automatic baro_regs_pkg::config_t exp_cfg();
    baro_regs_pkg::config_t c;
    c = '0;
    {c.sample_rate_sel, c.press_lpf_on, c.lpf_cutoff_sel, c.hold_until_read, c.spi_wire_sel} = mem[7'h10][6:0];
    {c.queue_on, c.halt_at_watermark, c.addr_autoinc, c.twowire_off} = mem[7'h11][6:3];
    {c.irq_polarity, c.irq_drive_sel, c.queue_full_route, c.watermark_route, c.overrun_route, c.data_ready_route,
     c.pin_source_sel} = mem[7'h12];
    {c.queue_mode_sel, c.watermark_level} = mem[7'h14];
    c.low_current_sel = mem[7'h1A][0];
    return c;
  endfunction

  task model_reset();
    foreach (mem[i]) mem[i] = 8'h00;
    mem[7'h11] = 8'h10;
  endtask

  task check_outs();
    `CHK(cfg, exp_cfg())
    `CHK(ref_pressure, {mem[7'h17], mem[7'h16], mem[7'h15]})
    `CHK(press_offset, {mem[7'h19], mem[7'h18]})
    `CHK(twowire_en, ~mem[7'h11][3])
  endtask

  task wr(input logic [6:0] ad, input logic [7:0] dv, input logic keep);
    u_host.write_reg(ad, dv, keep);
    // Self-clearing bits are never stored
    case (ad)
      7'h10: mem[ad] = dv & 8'h7F;
      7'h11: mem[ad] = dv & 8'h78;
      7'h1A: mem[ad] = dv & 8'h01;
      7'h12, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19: mem[ad] = dv;
      default: ;
    endcase
    repeat (2) @(negedge sys_clk);
    check_outs();
  endtask

  task rd(input logic [6:0] ad, input logic [7:0] ev);
    u_host.read_reg(ad, d);
    `CHK(d, ev)
  endtask

  task chk_all();
    foreach (amap[i]) rd(amap[i], mem[amap[i]]);
    check_outs();
  endtask

  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  task poll();
    for (int i = 0; i < 60; i++) begin
      u_host.read_reg(7'h11, d);
      if ((d & 8'h85) == 8'h00) return;
    end
    bad_count++;
    $display("[FAIL] %0t self-clear timeout", $time);
  endtask

  task close_out();
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    amap = '{7'h10, 7'h11, 7'h12, 7'h14, 7'h15, 7'h16, 7'h17, 7'h18, 7'h19, 7'h1A};
    model_reset();
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    `CHK(out_update_en, 1'b1)
    `CHK(irq_pin_oe_n, 1'b0)
    `CHK(conv_busy, 1'b0)
    chk_all();
    rd(7'h13, 8'h00);
    rd(7'h1B, 8'h00);
    for (k = 0; k < 40; k++) begin
      a = amap[{$random(seed)} % 10];
      v = 8'($random(seed));
      if (a == 7'h11) v = v & 8'h7A;
      // Host never writes the reserved queue codes
      if (a == 7'h14 && (v[7:5] == 3'h5 || v[7:5] == 3'h6)) v[5] = ~v[5];
      wr(a, v, 1'b1);
      rd(a, mem[a]);
    end
    wr(7'h10, 8'h8F, 1'b0);
    rd(7'h10, 8'h0F);
    wr(7'h1A, 8'hFF, 1'b0);
    rd(7'h1A, 8'h01);
    // Single shot after any earlier single-shot conversion has drained
    for (k = 0; k < 400 && conv_busy !== 1'b0; k++) @(negedge sys_clk);
    k = n_start;
    wr(7'h11, mem[7'h11] | 8'h01, 1'b1);
    `CHK(n_start - k, 1)
    u_host.read_reg(7'h11, d);
    `CHK(d[0], 1'b1)
    for (k = 0; k < 400 && conv_busy !== 1'b0; k++) @(negedge sys_clk);
    rd(7'h11, mem[7'h11]);
    pulse(out_upper_rd);
    `CHK(out_update_en, 1'b0)
    pulse(out_lower_rd);
    `CHK(out_update_en, 1'b1)
    // Trigger refused while a continuous rate runs
    wr(7'h10, 8'h10, 1'b1);
    wr(7'h11, mem[7'h11] | 8'h01, 1'b1);
    `CHK(conv_busy, 1'b0)
    wr(7'h10, 8'h00, 1'b1);
    pulse(out_upper_rd);
    `CHK(out_update_en, 1'b1)
    for (k = 0; k < 24; k++) begin
      v = 8'($random(seed));
      v[1:0] = k[1:0];
      // Open drain only with active low, where the pin level is unambiguous
      if (v[6]) v[7] = 1'b1;
      wr(7'h12, v, 1'b1);
      events_in = 6'($random(seed));
      repeat (3) @(negedge sys_clk);
      case (v[1:0])
        2'b00: act = (events_in.sample_ready_signal & v[2]) | (events_in.watermark & v[4]) |
                     (events_in.overrun & v[3]) | (events_in.queue_full & v[5]);
        2'b01: act = events_in.press_high;
        2'b10: act = events_in.press_low;
        default: act = events_in.press_high | events_in.press_low;
      endcase
      `CHK(irq_pin_oe_n ? 1'b1 : irq_pin_o, act ^ v[7])
      if (!v[6]) `CHK(irq_pin_oe_n, 1'b0)
    end
    wr(7'h15, 8'h5A, 1'b1);
    u_host.write_reg(7'h11, mem[7'h11] | 8'h80, 1'b1);
    poll();
    chk_all();
    `CHK(trim_word, 8'hC4)
    u_host.write_reg(7'h11, mem[7'h11] | 8'h84, 1'b1);
    poll();
    model_reset();
    chk_all();
    wr(7'h19, 8'hA5, 1'b1);
    reset_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    model_reset();
    chk_all();
    close_out();
  end
endmodule
